// ---- design/dtlsc_pkg.sv ----
/*
  Shared constants of the time-loop and sync-out control register bank:
  byte addresses, field positions, reset values and limits.
  Assumes byte-wide register ports with 12-bit byte addresses.
*/
`default_nettype none
package dtlsc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_DELAY0 = 12'h928;
  localparam logic [ADDR_W-1:0] ADDR_DELAY3 = 12'h92b;
  localparam logic [ADDR_W-1:0] ADDR_DIFF0 = 12'h92c;
  localparam logic [ADDR_W-1:0] ADDR_DIFF3 = 12'h92f;
  localparam logic [ADDR_W-1:0] ADDR_START0 = 12'h930;
  localparam logic [ADDR_W-1:0] ADDR_START1 = 12'h931;
  localparam logic [ADDR_W-1:0] ADDR_SPEED0 = 12'h932;
  localparam logic [ADDR_W-1:0] ADDR_SPEED1 = 12'h933;
  localparam logic [ADDR_W-1:0] ADDR_DIFF_DEPTH = 12'h934;
  localparam logic [ADDR_W-1:0] ADDR_SPEED_DEPTH = 12'h935;
  localparam logic [ADDR_W-1:0] ADDR_OWNER = 12'h980;
  localparam logic [ADDR_W-1:0] ADDR_ACT = 12'h981;
  // ownership register bits
  localparam int OWN_SYNC = 0;
  localparam int OWN_LATCH0 = 4;
  localparam int OWN_LATCH1 = 5;
  localparam logic [7:0] OWN_MASK = 8'h31;
  // activation register bits
  localparam int ACT_UNIT = 0;
  localparam int ACT_P0 = 1;
  localparam int ACT_P1 = 2;
  localparam int ACT_AUTO = 3;
  localparam int ACT_EXT = 4;
  localparam int ACT_PLAUS = 5;
  localparam int ACT_NEAR = 6;
  localparam int ACT_DEBUG = 7;
  localparam logic [7:0] ACT_MASK = 8'h7f;
  localparam int NEAR_SHORT_BIT = 31;
  // field widths and limits
  localparam int START_W = 15;
  localparam int DEPTH_W = 4;
  localparam logic [7:0] START_HI_MASK = 8'h7f;
  localparam logic [7:0] DEPTH_MASK = 8'h0f;
  localparam logic [15:0] SPEED_LIMIT_OFS = 16'h007f;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : dtlsc_pkg
`default_nettype wire

// ---- design/dtlsc_avg_filter.sv ----
/*
  Running-average filter: each sample moves the average by the error
  shifted right by the depth. Clear returns the average to zero.
  Assumes samples and clear come from logic on the same clock.
*/
`default_nettype none
module dtlsc_avg_filter #(
  parameter int W = 32,
  parameter int DW = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic signed [W-1:0] i_sample,
  input wire logic [DW-1:0] i_depth,
  output logic signed [W-1:0] o_avg
);
  logic signed [W:0] err;

  assign err = $signed({i_sample[W-1], i_sample}) - $signed({o_avg[W-1], o_avg});

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avg <= '0;
    end else if (i_clear) begin
      o_avg <= '0;
    end else if (i_valid) begin
      o_avg <= W'(o_avg + W'(err >>> i_depth));
    end
  end
endmodule : dtlsc_avg_filter
`default_nettype wire

// ---- design/dtlsc_sync_ctrl.sv ----
/*
  Sync-out activation register with auto-activation, start time
  extension, near-future plausibility check and debug pulse.
  Assumes write strobes are already filtered by port ownership.
*/
`default_nettype none
module dtlsc_sync_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  input wire logic i_start_wr,
  input wire logic i_start_lo_only,
  input wire logic [63:0] i_start_time,
  input wire logic [63:0] i_sys_time,
  output logic [7:0] o_act,
  output logic [1:0] o_debug,
  output logic o_immediate,
  output logic o_start_valid,
  output logic [63:0] o_start
);
  import dtlsc_pkg::*;

  logic [7:0] act_d;
  logic [63:0] start_eff;
  logic [63:0] delta;
  logic outside;
  logic activate;

  always_comb begin
    start_eff = i_start_time;
    if (i_start_lo_only && o_act[ACT_EXT]) begin
      start_eff[63:32] = i_sys_time[63:32];
      if (i_start_time[31:0] < i_sys_time[31:0]) begin
        start_eff[63:32] = i_sys_time[63:32] + 32'h0000_0001; // RULE17
      end
    end
  end

  assign delta = start_eff - i_sys_time;
  // short window is 2^31 ns, long window half the 64-bit range
  assign outside = o_act[ACT_NEAR] ? (delta[63:NEAR_SHORT_BIT] != '0) : delta[63]; // RULE19

  always_comb begin
    act_d = o_act;
    if (i_we) begin
      act_d = i_wdata & ACT_MASK; // RULE15
    end
    if (i_start_wr && o_act[ACT_AUTO]) begin
      act_d[ACT_UNIT] = 1'b1; // RULE16
    end
  end

  assign activate = act_d[ACT_UNIT] && !o_act[ACT_UNIT];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_act <= RST_BYTE;
    end else begin
      o_act <= act_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_debug <= 2'h0;
    end else if (i_we && i_wdata[ACT_DEBUG]) begin
      o_debug <= act_d[ACT_P1:ACT_P0]; // RULE20
    end else begin
      o_debug <= 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_immediate <= 1'b0;
    end else begin
      o_immediate <= activate && act_d[ACT_PLAUS] && outside; // RULE18
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_start_valid <= 1'b0;
      o_start <= '0;
    end else begin
      o_start_valid <= i_start_wr;
      if (i_start_wr) begin
        o_start <= start_eff; // RULE17
      end
    end
  end

  // a pulse stands only in the cycle after a debug write
  chk_debug_self_clear: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE20
    !o_act[ACT_DEBUG] && (o_debug == 2'h0 || $past(i_we && i_wdata[ACT_DEBUG])))
    else $error("debug pulse longer than one cycle or bit reads one");
  chk_auto_activate: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE16
    i_start_wr && o_act[ACT_AUTO] |=> o_act[ACT_UNIT])
    else $error("start write did not auto-activate");
  chk_plaus_off: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE18
    !act_d[ACT_PLAUS] |=> !o_immediate)
    else $error("immediate sync without plausibility check");
endmodule : dtlsc_sync_ctrl
`default_nettype wire

// ---- design/dtlsc_top.sv ----
/*
  Time-loop and sync-out control register bank with two byte-wide
  register ports: network master port (m) and local host port (h).
  Assumes the time loop supplies difference and speed samples and the
  system time on this clock; the host-controlled strap is a pin.
*/
//
// Overview of operation
// (RULE1) 32-bit reference path delay, both ports read
// (RULE2) software restarts filters after delay change
// (RULE3) difference magnitude bits 30:0, bit 31 sign
// (RULE4) 15-bit bandwidth field, larger means smoother
// (RULE5) bandwidth write clears difference and deviation
// (RULE6) software keeps bandwidth in 0x0080..0x3fff
// (RULE7) deviation clamped to plus/minus start minus 0x7f
// (RULE8) software computes deviation after difference settles
// (RULE9) difference depth write clears averaged difference
// (RULE10) speed depth write resets speed filter
// (RULE11) time loop writes: master, host if host-controlled
// (RULE12) ownership bit 0: sync unit, master-only writes
// (RULE13) bit 4 latch0 owner, forced host when host-controlled
// (RULE14) bit 5 latch1 owner, routes latch interrupt
// (RULE15) activation bits 0..2 reset to zero
// (RULE16) auto-activation on start time write
// (RULE17) 32-bit start time extended to 64
// (RULE18) plausibility check gives immediate sync
// (RULE19) bit 6 selects near-future window
// (RULE20) debug pulse bit self-clears, reads zero
// (RULE21) activation writes follow sync unit owner
// (RULE22) unknown resets zero, reserved bits zero
`default_nettype none
module dtlsc_top #(
  parameter int DIFF_W = 32,
  parameter int SPEED_W = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_time_host_ctrl,
  input wire logic i_m_wr,
  input wire logic i_m_rd,
  input wire logic [dtlsc_pkg::ADDR_W-1:0] i_m_addr,
  input wire logic [7:0] i_m_wdata,
  output logic [7:0] o_m_rdata,
  output logic o_m_rvalid,
  input wire logic i_h_wr,
  input wire logic i_h_rd,
  input wire logic [dtlsc_pkg::ADDR_W-1:0] i_h_addr,
  input wire logic [7:0] i_h_wdata,
  output logic [7:0] o_h_rdata,
  output logic o_h_rvalid,
  input wire logic i_diff_valid,
  input wire logic signed [DIFF_W-1:0] i_diff_sample,
  input wire logic i_speed_valid,
  input wire logic signed [SPEED_W-1:0] i_speed_sample,
  input wire logic i_start_wr,
  input wire logic i_start_lo_only,
  input wire logic [63:0] i_start_time,
  input wire logic [63:0] i_sys_time,
  output logic [31:0] o_ref_delay,
  output logic [dtlsc_pkg::START_W-1:0] o_bandwidth,
  output logic [dtlsc_pkg::DEPTH_W-1:0] o_diff_depth,
  output logic [dtlsc_pkg::DEPTH_W-1:0] o_speed_depth,
  output logic o_sync_host,
  output logic o_latch0_host,
  output logic o_latch1_host,
  output logic o_unit_active,
  output logic [1:0] o_pulse_en,
  output logic [1:0] o_debug_pulse,
  output logic o_sync_immediate,
  output logic o_start_valid,
  output logic [63:0] o_start_time
);
  import dtlsc_pkg::*;

  logic host_meta_q;
  logic host_q;
  logic [7:0] own_q;
  logic [7:0] act;
  logic tl_wr_m;
  logic tl_wr_h;
  logic tl_we;
  logic [ADDR_W-1:0] tl_addr;
  logic [7:0] tl_data;
  logic start_wr;
  logic diff_clr;
  logic speed_clr;
  logic act_we;
  logic [7:0] act_wdata;
  logic signed [DIFF_W-1:0] diff_avg;
  logic signed [SPEED_W-1:0] speed_avg;
  logic [31:0] diff_rep_q;
  logic [15:0] speed_dev_q;
  logic [15:0] limit;
  logic signed [15:0] speed_clamped;
  logic [DIFF_W-1:0] diff_mag;

  // replace one byte of a word
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] idx,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[8*idx +: 8] = b;
    return r;
  endfunction

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
    logic [7:0] r;
    r = RST_BYTE;
    if (in_range(a, ADDR_DELAY0, ADDR_DELAY3)) begin
      r = o_ref_delay[8*a[1:0] +: 8]; // RULE1
    end else if (in_range(a, ADDR_DIFF0, ADDR_DIFF3)) begin
      r = diff_rep_q[8*a[1:0] +: 8];
    end else if (a == ADDR_START0) begin
      r = o_bandwidth[7:0];
    end else if (a == ADDR_START1) begin
      r = {1'b0, o_bandwidth[START_W-1:8]}; // RULE22
    end else if (a == ADDR_SPEED0) begin
      r = speed_dev_q[7:0];
    end else if (a == ADDR_SPEED1) begin
      r = speed_dev_q[15:8];
    end else if (a == ADDR_DIFF_DEPTH) begin
      r = {4'h0, o_diff_depth};
    end else if (a == ADDR_SPEED_DEPTH) begin
      r = {4'h0, o_speed_depth};
    end else if (a == ADDR_OWNER) begin
      r = own_q;
      r[OWN_LATCH0] = own_q[OWN_LATCH0] | host_q; // RULE13
    end else if (a == ADDR_ACT) begin
      r = act; // RULE20
    end
    return r;
  endfunction

  // strap from a pin: two flops before use
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      host_meta_q <= 1'b0;
      host_q <= 1'b0;
    end else begin
      host_meta_q <= i_time_host_ctrl;
      host_q <= host_meta_q;
    end
  end

  // time loop write path: one owner at a time
  assign tl_wr_m = i_m_wr && !host_q; // RULE11
  assign tl_wr_h = i_h_wr && host_q; // RULE11
  assign tl_we = tl_wr_m || tl_wr_h;
  assign tl_addr = tl_wr_m ? i_m_addr : i_h_addr;
  assign tl_data = tl_wr_m ? i_m_wdata : i_h_wdata;
  assign start_wr = tl_we && in_range(tl_addr, ADDR_START0, ADDR_START1);
  assign diff_clr = start_wr || (tl_we && tl_addr == ADDR_DIFF_DEPTH); // RULE5 RULE9
  assign speed_clr = start_wr || (tl_we && tl_addr == ADDR_SPEED_DEPTH); // RULE5 RULE10

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_delay <= RST_WORD;
    end else if (tl_we && in_range(tl_addr, ADDR_DELAY0, ADDR_DELAY3)) begin
      o_ref_delay <= put_byte(o_ref_delay, tl_addr[1:0], tl_data); // RULE1
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bandwidth <= '0;
    end else if (tl_we && tl_addr == ADDR_START0) begin
      o_bandwidth[7:0] <= tl_data; // RULE4
    end else if (tl_we && tl_addr == ADDR_START1) begin
      o_bandwidth[START_W-1:8] <= tl_data[6:0] & START_HI_MASK[6:0]; // RULE4
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_diff_depth <= '0;
      o_speed_depth <= '0;
    end else if (tl_we && tl_addr == ADDR_DIFF_DEPTH) begin
      o_diff_depth <= DEPTH_W'(tl_data & DEPTH_MASK); // RULE9
    end else if (tl_we && tl_addr == ADDR_SPEED_DEPTH) begin
      o_speed_depth <= DEPTH_W'(tl_data & DEPTH_MASK); // RULE10
    end
  end

  // ownership register: master port only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      own_q <= RST_BYTE;
    end else if (i_m_wr && i_m_addr == ADDR_OWNER) begin
      own_q <= i_m_wdata & OWN_MASK; // RULE12 RULE14
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sync_host <= 1'b0;
      o_latch0_host <= 1'b0;
      o_latch1_host <= 1'b0;
    end else begin
      o_sync_host <= own_q[OWN_SYNC]; // RULE12
      o_latch0_host <= own_q[OWN_LATCH0] | host_q; // RULE13
      o_latch1_host <= own_q[OWN_LATCH1]; // RULE14
    end
  end

  // activation writes from the sync unit owner only
  assign act_we = own_q[OWN_SYNC] ? (i_h_wr && i_h_addr == ADDR_ACT)
                                  : (i_m_wr && i_m_addr == ADDR_ACT); // RULE21
  assign act_wdata = own_q[OWN_SYNC] ? i_h_wdata : i_m_wdata;

  dtlsc_sync_ctrl u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_we(act_we),
    .i_wdata(act_wdata),
    .i_start_wr(i_start_wr),
    .i_start_lo_only(i_start_lo_only),
    .i_start_time(i_start_time),
    .i_sys_time(i_sys_time),
    .o_act(act),
    .o_debug(o_debug_pulse),
    .o_immediate(o_sync_immediate),
    .o_start_valid(o_start_valid),
    .o_start(o_start_time)
  );

  assign o_unit_active = act[ACT_UNIT];
  assign o_pulse_en = act[ACT_P1:ACT_P0];

  dtlsc_avg_filter #(.W(DIFF_W), .DW(DEPTH_W)) u_diff (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(diff_clr),
    .i_valid(i_diff_valid),
    .i_sample(i_diff_sample),
    .i_depth(o_diff_depth),
    .o_avg(diff_avg)
  );

  dtlsc_avg_filter #(.W(SPEED_W), .DW(DEPTH_W)) u_speed (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(speed_clr),
    .i_valid(i_speed_valid),
    .i_sample(i_speed_sample),
    .i_depth(o_speed_depth),
    .o_avg(speed_avg)
  );

  // sample is local minus received: negative means local is behind
  assign diff_mag = diff_avg[DIFF_W-1] ? DIFF_W'(-diff_avg) : diff_avg;

  assign limit = ({1'b0, o_bandwidth} > SPEED_LIMIT_OFS) ?
                 16'({1'b0, o_bandwidth} - SPEED_LIMIT_OFS) : 16'h0000;

  always_comb begin
    speed_clamped = 16'(speed_avg);
    if (speed_clamped > $signed(limit)) begin
      speed_clamped = $signed(limit); // RULE7
    end else if (speed_clamped < -$signed(limit)) begin
      speed_clamped = -$signed(limit); // RULE7
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      diff_rep_q <= RST_WORD;
      speed_dev_q <= 16'h0000;
    end else begin
      diff_rep_q <= diff_clr ? RST_WORD : {diff_avg[DIFF_W-1], diff_mag[30:0]}; // RULE3 RULE5
      speed_dev_q <= speed_clr ? 16'h0000 : speed_clamped; // RULE5 RULE7
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_m_rdata <= RST_BYTE;
      o_m_rvalid <= 1'b0;
      o_h_rdata <= RST_BYTE;
      o_h_rvalid <= 1'b0;
    end else begin
      o_m_rvalid <= i_m_rd;
      o_h_rvalid <= i_h_rd;
      if (i_m_rd) begin
        o_m_rdata <= read_byte(i_m_addr);
      end
      if (i_h_rd) begin
        o_h_rdata <= read_byte(i_h_addr);
      end
    end
  end

  sequence s_start_write;
    start_wr;
  endsequence
  sequence s_both_clear;
    diff_rep_q == RST_WORD && speed_dev_q == 16'h0000;
  endsequence

  chk_delay_host_block: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE11
    !host_q && !i_m_wr |=> $stable(o_ref_delay))
    else $error("delay changed without a permitted write");
  chk_start_clears: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE5
    s_start_write |=> s_both_clear)
    else $error("bandwidth write did not clear difference and deviation");
  chk_depth_clears: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE9
    tl_we && tl_addr == ADDR_DIFF_DEPTH |=> diff_rep_q == RST_WORD)
    else $error("difference depth write did not clear average");
  chk_speed_bound: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE7
    $signed(speed_dev_q) <= $signed(limit) || $changed(o_bandwidth))
    else $error("deviation above bound");
  chk_owner_master: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE12
    !(i_m_wr && i_m_addr == ADDR_OWNER) |=> $stable(own_q))
    else $error("ownership changed without master write");
  chk_latch0_forced: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE13
    host_q && $past(host_q) |-> o_latch0_host)
    else $error("latch0 not host owned while host controls time");
  chk_sign_bit: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE3
    !diff_clr |=> diff_rep_q[31] == $past(diff_avg[DIFF_W-1]))
    else $error("difference sign bit wrong");
  chk_act_owner: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE21
    own_q[OWN_SYNC] && i_m_wr && i_m_addr == ADDR_ACT && !i_h_wr && !i_start_wr
    |=> act == $past(act))
    else $error("master wrote activation while host owns it");
endmodule : dtlsc_top
`default_nettype wire

// ---- tb/dtlsc_port_model.sv ----
/*
  Byte-port driver standing in for the network master (port 0) and the
  local host (port 1). Assumes the one-cycle strobe protocol of the bank.
*/
`default_nettype none
module dtlsc_port_model (
  input wire logic i_clk,
  output var logic o_m_wr,
  output var logic o_m_rd,
  output var logic [dtlsc_pkg::ADDR_W-1:0] o_m_addr,
  output var logic [7:0] o_m_wdata,
  input wire logic [7:0] i_m_rdata,
  input wire logic i_m_rvalid,
  output var logic o_h_wr,
  output var logic o_h_rd,
  output var logic [dtlsc_pkg::ADDR_W-1:0] o_h_addr,
  output var logic [7:0] o_h_wdata,
  input wire logic [7:0] i_h_rdata,
  input wire logic i_h_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtlsc_pkg::*;
  logic [1:0] wr_s = 2'b00;
  logic [1:0] rd_s = 2'b00;
  logic [ADDR_W-1:0] ad_s [2] = '{12'h000, 12'h000};
  logic [7:0] wd_s [2] = '{8'h00, 8'h00};
  assign o_m_wr = wr_s[0];
  assign o_m_rd = rd_s[0];
  assign o_m_addr = ad_s[0];
  assign o_m_wdata = wd_s[0];
  assign o_h_wr = wr_s[1];
  assign o_h_rd = rd_s[1];
  assign o_h_addr = ad_s[1];
  assign o_h_wdata = wd_s[1];
  task automatic wr(input logic p, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr_s[p] <= 1'b1;
    ad_s[p] <= a;
    wd_s[p] <= d;
    @(posedge i_clk);
    wr_s[p] <= 1'b0;
    // released lines must not keep the last value
    ad_s[p] <= ~a;
    wd_s[p] <= ~d;
  endtask
  task automatic rd(input logic p, input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    rd_s[p] <= 1'b1;
    ad_s[p] <= a;
    @(posedge i_clk);
    rd_s[p] <= 1'b0;
    ad_s[p] <= ~a;
    #1;
    d = (p ? i_h_rvalid : i_m_rvalid) ? (p ? i_h_rdata : i_m_rdata) : 8'hxx;
  endtask
endmodule // dtlsc_port_model
`default_nettype wire

// ---- tb/dtlsc_top_test.sv ----
/*
  Self-checking bench of the time-loop and sync-out register bank.
  Assumes the port model drives both register ports; samples, strap and
  start-time writes are driven here.
*/
`default_nettype none
module dtlsc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dtlsc_pkg::*;
  logic clk = 1'b0;
  logic resetn, strap, m_wr, m_rd, h_wr, h_rd, dv, sv, st_wr, st_lo, m_rv, h_rv;
  logic [ADDR_W-1:0] m_addr, h_addr;
  logic [7:0] m_wd, h_wd, m_rdata, h_rdata;
  logic signed [31:0] d_smp;
  logic signed [15:0] s_smp;
  logic [63:0] st_time, sys_time, start_o, got;
  logic [31:0] ref_delay, v;
  logic [14:0] bw;
  logic [3:0] dd, sd;
  logic sync_h, l0_h, l1_h, unit_act, imm, st_valid, seen;
  logic [1:0] pen, dbg;
  logic [7:0] pc [4] = '{8'h28, 8'h68, 8'h48, 8'h28};
  logic [63:0] ps [4] = '{64'h8000_0100, 64'h8000_0100, 64'h8000_0100, 64'h8000_0000_0000_0100};
  logic pe [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int fail_count = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  dtlsc_port_model pm (.i_clk(clk), .o_m_wr(m_wr), .o_m_rd(m_rd), .o_m_addr(m_addr),
    .o_m_wdata(m_wd), .i_m_rdata(m_rdata), .i_m_rvalid(m_rv), .o_h_wr(h_wr), .o_h_rd(h_rd),
    .o_h_addr(h_addr), .o_h_wdata(h_wd), .i_h_rdata(h_rdata), .i_h_rvalid(h_rv));
  dtlsc_top dtlsc_top_i (.i_clk(clk), .i_resetn(resetn), .i_time_host_ctrl(strap),
    .i_m_wr(m_wr), .i_m_rd(m_rd), .i_m_addr(m_addr), .i_m_wdata(m_wd), .o_m_rdata(m_rdata),
    .o_m_rvalid(m_rv), .i_h_wr(h_wr), .i_h_rd(h_rd), .i_h_addr(h_addr), .i_h_wdata(h_wd),
    .o_h_rdata(h_rdata), .o_h_rvalid(h_rv), .i_diff_valid(dv), .i_diff_sample(d_smp),
    .i_speed_valid(sv), .i_speed_sample(s_smp), .i_start_wr(st_wr), .i_start_lo_only(st_lo),
    .i_start_time(st_time), .i_sys_time(sys_time), .o_ref_delay(ref_delay), .o_bandwidth(bw),
    .o_diff_depth(dd), .o_speed_depth(sd), .o_sync_host(sync_h), .o_latch0_host(l0_h),
    .o_latch1_host(l1_h), .o_unit_active(unit_act), .o_pulse_en(pen), .o_debug_pulse(dbg),
    .o_sync_immediate(imm), .o_start_valid(st_valid), .o_start_time(start_o));
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic p, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] r;
    pm.rd(p, a, r);
    chk(64'(r), 64'(e));
  endtask
  task automatic rd32(input logic p, input logic [ADDR_W-1:0] a, output logic [31:0] w);
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      pm.rd(p, a + ADDR_W'(i), r);
      w[8*i +: 8] = r;
    end
  endtask
  task automatic smp(input logic signed [31:0] d, input logic signed [15:0] s);
    @(posedge clk);
    dv <= 1'b1;
    sv <= 1'b1;
    d_smp <= d;
    s_smp <= s;
    @(posedge clk);
    dv <= 1'b0;
    sv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stw(input logic lo, input logic [63:0] s, input logic [63:0] y,
                     output logic sn, output logic [63:0] g);
    @(posedge clk);
    st_wr <= 1'b1;
    st_lo <= lo;
    st_time <= s;
    sys_time <= y;
    @(posedge clk);
    st_wr <= 1'b0;
    sn = 1'b0;
    g = 'x;
    repeat (4) begin
      #1;
      sn = sn | imm;
      if (st_valid === 1'b1) g = start_o;
      @(posedge clk);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    {strap, dv, sv, st_wr, st_lo} = 5'h00;
    d_smp = 32'sh0;
    s_smp = 16'sh0;
    st_time = 64'h0;
    sys_time = 64'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 'h928; a <= 'h936; a++) rchk(0, ADDR_W'(a), 8'h00);
    rchk(1, ADDR_OWNER, 8'h00);
    rchk(1, ADDR_ACT, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) pm.wr(0, ADDR_DELAY0 + ADDR_W'(i), 8'(32'h89ab_cdef >> 8*i));
    pm.wr(1, ADDR_DELAY0, 8'h33);
    rd32(1, ADDR_DELAY0, v);
    chk(64'(v), 64'h89ab_cdef);
    chk(64'(ref_delay), 64'h89ab_cdef);
    pm.wr(0, ADDR_START0, 8'h00);
    pm.wr(0, ADDR_START1, 8'h81);
    rchk(0, ADDR_START1, 8'h01);
    chk(64'(bw), 64'h0100);
    pm.wr(0, ADDR_DIFF_DEPTH, 8'hf2);
    rchk(1, ADDR_DIFF_DEPTH, 8'h02);
    chk(64'(dd), 64'h2);
    pm.wr(0, ADDR_DIFF_DEPTH, 8'h00);
    pm.wr(0, ADDR_SPEED_DEPTH, 8'hf3);
    rchk(1, ADDR_SPEED_DEPTH, 8'h03);
    chk(64'(sd), 64'h3);
    pm.wr(0, ADDR_SPEED_DEPTH, 8'h00);
    $display("test config done");
    smp(-32'sd5, 16'sh0200);
    rd32(0, ADDR_DIFF0, v);
    chk(64'(v), 64'h8000_0005);
    rd32(1, ADDR_START0, v);
    chk(64'(v), 64'h0081_0100);
    smp(32'sd7, -16'sd16);
    rd32(0, ADDR_DIFF0, v);
    chk(64'(v), 64'h0000_0007);
    rd32(0, ADDR_START0, v);
    chk(64'(v), 64'hfff0_0100);
    pm.wr(0, ADDR_START0, 8'h00);
    rd32(0, ADDR_DIFF0, v);
    chk(64'(v), 64'h0);
    rd32(0, ADDR_START0, v);
    chk(64'(v), 64'h0000_0100);
    smp(-32'sd5, 16'sh0200);
    pm.wr(0, ADDR_DIFF_DEPTH, 8'h00);
    rd32(0, ADDR_DIFF0, v);
    chk(64'(v), 64'h0);
    rd32(0, ADDR_START0, v);
    chk(64'(v), 64'h0081_0100);
    pm.wr(1, ADDR_SPEED_DEPTH, 8'h00);
    pm.wr(0, ADDR_SPEED_DEPTH, 8'h00);
    rd32(0, ADDR_START0, v);
    chk(64'(v), 64'h0000_0100);
    $display("test filters done");
    @(posedge clk) strap <= 1'b1;
    repeat (3) @(posedge clk);
    pm.wr(0, ADDR_DELAY0, 8'h11);
    pm.wr(1, ADDR_DELAY0 + 12'h001, 8'h22);
    rd32(0, ADDR_DELAY0, v);
    chk(64'(v), 64'h89ab_22ef);
    rchk(0, ADDR_OWNER, 8'h10);
    chk(64'(l0_h), 64'h1);
    @(posedge clk) strap <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(0, ADDR_OWNER, 8'h00);
    pm.wr(1, ADDR_OWNER, 8'hff);
    rchk(0, ADDR_OWNER, 8'h00);
    pm.wr(0, ADDR_OWNER, 8'hff);
    rchk(1, ADDR_OWNER, 8'h31);
    chk(64'({sync_h, l0_h, l1_h}), 64'h7);
    pm.wr(0, ADDR_ACT, 8'h07);
    pm.wr(1, ADDR_ACT, 8'h06);
    rchk(0, ADDR_ACT, 8'h06);
    pm.wr(0, ADDR_OWNER, 8'h00);
    pm.wr(1, ADDR_ACT, 8'h00);
    rchk(1, ADDR_ACT, 8'h06);
    $display("test ownership done");
    pm.wr(0, ADDR_ACT, 8'h87);
    #1;
    chk(64'(dbg), 64'h3);
    @(posedge clk);
    #1;
    chk(64'(dbg), 64'h0);
    rchk(0, ADDR_ACT, 8'h07);
    chk(64'({unit_act, pen}), 64'h7);
    pm.wr(0, ADDR_ACT, 8'h00);
    stw(1'b0, 64'h100, 64'h0, seen, got);
    rchk(0, ADDR_ACT, 8'h00);
    pm.wr(0, ADDR_ACT, 8'h08);
    stw(1'b0, 64'h100, 64'h0, seen, got);
    chk(got, 64'h100);
    rchk(0, ADDR_ACT, 8'h09);
    pm.wr(0, ADDR_ACT, 8'h10);
    stw(1'b1, 64'h10, 64'h0000_0005_0000_0020, seen, got);
    chk(got, 64'h0000_0006_0000_0010);
    for (int i = 0; i < 4; i++) begin
      pm.wr(0, ADDR_ACT, pc[i]);
      stw(1'b0, ps[i], 64'h100, seen, got);
      chk(64'(seen), 64'(pe[i]));
    end
    $display("test sync done");
    conclude();
  end
endmodule // dtlsc_top_test
`default_nettype wire
